// ==== design/txhw_regs.sv ====
// Transmit control and hardware setup registers behind an APB slave.
//
// Function
// - While transmit enable is set, the transmitter sends held FIFO data.
// - Transmit enable clears itself once a requested stop has halted.
// - Stop request finishes the current frame, then transmission ceases.
// - Stop request self-clears when the transmitter has stopped.
// - Writes to the stop request bit are ignored while it reads one.
// - When stop request clears, no frame data remains in the datapath.
// - Writing one to flush resets FIFO pointers; the bit self-clears.
// - Without a PROM, emulation select picks defaults or descriptor RAM.
// - Emulation select has no effect while a PROM is present.
// - Guard bit keeps chosen fields through all resets except power-on.
// - Emulation select and the guard bit itself are guarded fields.
// - Empty bulk-in reply is zero-length packet when bit 12 is zero, NAK if one.
// - Fast light bit shortens light on/off times from 80 ms to 15 us.
// - Receive packets start with 0 to 3 pad bytes from bits 10:9.
// - On loss of sync, stall bulk-out unless bit 8 is set.
// - Halted flag rises on a single pulse when a requested stop halts.
`timescale 1ns/100ps
module txhw_regs #(
  parameter int SLOW_CYC = txhw_pkg::LED_SLOW_CYC
) (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  input  wire logic        POR_N_I,
  input  wire logic        CE_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  input  wire logic        FRAME_BUSY_I,
  input  wire logic        PROM_PRESENT_I,
  input  wire logic        RX_EMPTY_I,
  input  wire logic        SYNC_LOST_I,
  input  wire logic        ACTIVITY_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             TX_ENABLE_O,
  output logic             TX_FLUSH_O,
  output logic             USE_DESC_RAM_O,
  output logic             EMPTY_NAK_O,
  output logic             EMPTY_ZLP_O,
  output logic             OUTPIPE_STALL_O,
  output logic [1:0]       RX_PAD_BYTES_O,
  output logic             ACT_LED_O,
  output logic             IRQ_O
);
  import txhw_pkg::*;

  txhw_link_if lnk ();

  logic [1:0]  rst_sync_r;
  logic [1:0]  por_sync_r;
  logic [1:0]  busy_s_r;
  logic [1:0]  prom_s_r;
  logic [1:0]  empty_s_r;
  logic [1:0]  sync_s_r;
  logic [1:0]  act_s_r;
  logic        on_r;
  logic        stop_r;
  logic        flush_r;
  logic        guard_r;
  logic        emu_r;
  logic [31:0] cfg_r;
  logic        halt_sts_r;
  logic        halt_msk_r;
  logic [31:0] rdata_nxt;
  logic        rst_n;
  logic        por_n;

  // Reset release and guarded power-on release, each through two stages.
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  always_ff @(posedge CLOCK_I or negedge POR_N_I) begin
    if (!POR_N_I) begin
      por_sync_r <= 2'b00;
    end else begin
      por_sync_r <= {por_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];
  assign por_n = por_sync_r[1];

  // Pin inputs pass two flip-flops before use.
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      busy_s_r  <= 2'b00;
      prom_s_r  <= 2'b00;
      empty_s_r <= 2'b00;
      sync_s_r  <= 2'b00;
      act_s_r   <= 2'b00;
    end else if (CE_I) begin
      busy_s_r  <= {busy_s_r[0], FRAME_BUSY_I};
      prom_s_r  <= {prom_s_r[0], PROM_PRESENT_I};
      empty_s_r <= {empty_s_r[0], RX_EMPTY_I};
      sync_s_r  <= {sync_s_r[0], SYNC_LOST_I};
      act_s_r   <= {act_s_r[0], ACTIVITY_I};
    end
  end

  // APB decode: zero wait states, unmapped addresses answer with an error.
  wire acc      = PSEL_I && PENABLE_I;
  wire wr       = acc && PWRITE_I;
  wire hit_txc  = PADDR_I == OFS_TX_CTL;
  wire hit_hw   = PADDR_I == OFS_HW_SETUP;
  wire hit_sts  = PADDR_I == OFS_IRQ_STATUS;
  wire hit_msk  = PADDR_I == OFS_IRQ_MASK;
  wire hit_st   = PADDR_I == OFS_HW_STATE;
  wire mapped   = hit_txc || hit_hw || hit_sts || hit_msk || hit_st;
  wire lo_en    = PSTRB_I[0];
  wire b1_en    = PSTRB_I[1];
  wire b2_en    = PSTRB_I[2];
  wire wr_txc   = wr && hit_txc && lo_en;
  wire wr_hw1   = wr && hit_hw && b1_en;
  wire wr_hw2   = wr && hit_hw && b2_en;
  wire halt_ev  = lnk.halted_pulse;
  wire [31:0] cfg_wr = (cfg_r & ~{16'h0000, {8{b1_en}}, 8'h00})
                     | (PWDATA_I & HW_WR_MASK & {16'h0000, {8{b1_en}},
                        8'h00});

  // Transmit control: enable, stop request and flush.
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      on_r    <= TXC_RESET[TXC_ON_BIT];
      stop_r  <= TXC_RESET[TXC_STOP_BIT];
      flush_r <= TXC_RESET[TXC_FLUSH_BIT];
    end else if (CE_I) begin
      flush_r <= wr_txc && PWDATA_I[TXC_FLUSH_BIT];
      if (halt_ev) begin
        on_r   <= 1'b0;
        stop_r <= 1'b0;
      end else if (wr_txc) begin
        on_r <= PWDATA_I[TXC_ON_BIT];
        if (!stop_r) begin
          stop_r <= PWDATA_I[TXC_STOP_BIT];
        end
      end
    end
  end

  // Guard and emulation select survive resets other than power-on while guard is set.
  always_ff @(posedge CLOCK_I or negedge por_n) begin
    if (!por_n) begin
      guard_r <= HW_RESET[HW_GUARD_BIT];
      emu_r   <= HW_RESET[HW_EMUSEL_BIT];
    end else if (CE_I) begin
      if (!rst_n && !guard_r) begin
        guard_r <= HW_RESET[HW_GUARD_BIT];
        emu_r   <= HW_RESET[HW_EMUSEL_BIT];
      end else if (rst_n) begin
        if (wr_hw1) begin
          guard_r <= PWDATA_I[HW_GUARD_BIT];
        end
        if (wr_hw2) begin
          emu_r <= PWDATA_I[HW_EMUSEL_BIT];
        end
      end
    end
  end

  // Unguarded setup fields: bits 12 to 8.
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= HW_RESET & 32'h0000_1F00;
    end else if (CE_I && wr_hw1) begin
      cfg_r <= cfg_wr & 32'h0000_1F00;
    end
  end

  // Halted flag: sticky, write one to clear, set wins over clear.
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      halt_sts_r <= 1'b0;
      halt_msk_r <= 1'b0;
    end else if (CE_I) begin
      if (halt_ev) begin
        halt_sts_r <= 1'b1;
      end else if (wr && hit_sts && b2_en && PWDATA_I[IRQ_HALT_BIT]) begin
        halt_sts_r <= 1'b0;
      end
      if (wr && hit_msk && b2_en) begin
        halt_msk_r <= PWDATA_I[IRQ_HALT_BIT];
      end
    end
  end

  // Read data mux.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_txc) begin
      rdata_nxt[TXC_ON_BIT]   = on_r;
      rdata_nxt[TXC_STOP_BIT] = stop_r;
    end else if (hit_hw) begin
      rdata_nxt = cfg_r;
      rdata_nxt[HW_GUARD_BIT]  = guard_r;
      rdata_nxt[HW_EMUSEL_BIT] = emu_r;
    end else if (hit_sts) begin
      rdata_nxt[IRQ_HALT_BIT] = halt_sts_r;
    end else if (hit_msk) begin
      rdata_nxt[IRQ_HALT_BIT] = halt_msk_r;
    end else if (hit_st) begin
      rdata_nxt[0] = prom_s_r[1];
      rdata_nxt[1] = busy_s_r[1];
    end
  end

  assign lnk.tx_on    = on_r;
  assign lnk.stop_req = stop_r;
  assign lnk.led_fast = cfg_r[HW_LEDFAST_BIT];
  assign lnk.pad      = cfg_r[HW_PAD_LSB +: 2];

  txhw_engine #(.SLOW_CYC(SLOW_CYC)) u_engine (
    .clk_i        (CLOCK_I),
    .rst_n_i      (rst_n),
    .ce_i         (CE_I),
    .frame_busy_i (busy_s_r[1]),
    .activity_i   (act_s_r[1]),
    .lnk          (lnk)
  );

  // Registered outputs.
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA_O        <= 32'h0000_0000;
      PREADY_O        <= 1'b0;
      PSLVERR_O       <= 1'b0;
      TX_ENABLE_O     <= 1'b0;
      TX_FLUSH_O      <= 1'b0;
      USE_DESC_RAM_O  <= 1'b0;
      EMPTY_NAK_O     <= 1'b0;
      EMPTY_ZLP_O     <= 1'b0;
      OUTPIPE_STALL_O <= 1'b0;
      RX_PAD_BYTES_O  <= 2'b00;
      ACT_LED_O       <= 1'b0;
      IRQ_O           <= 1'b0;
    end else if (CE_I) begin
      PREADY_O  <= PSEL_I && !PENABLE_I;
      PSLVERR_O <= PSEL_I && !PENABLE_I && !mapped;
      if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
        PRDATA_O <= rdata_nxt;
      end
      TX_ENABLE_O    <= on_r;
      TX_FLUSH_O     <= flush_r;
      USE_DESC_RAM_O <= emu_r && !prom_s_r[1];
      EMPTY_NAK_O    <= empty_s_r[1] && cfg_r[HW_EMPTYNAK_BIT];
      EMPTY_ZLP_O    <= empty_s_r[1] && !cfg_r[HW_EMPTYNAK_BIT];
      OUTPIPE_STALL_O <= sync_s_r[1] && !cfg_r[HW_NOSTALL_BIT];
      RX_PAD_BYTES_O <= lnk.pad;
      ACT_LED_O      <= lnk.led_level;
      IRQ_O          <= (halt_sts_r || halt_ev) && halt_msk_r;
    end
  end
endmodule

// ==== design/txhw_pkg.sv ====
// Package with offsets, fields, resets and timing for the control registers.
package txhw_pkg;
  localparam int          CLK_MHZ         = 250;
  localparam logic [11:0] OFS_TX_CTL      = 12'h010;
  localparam logic [11:0] OFS_HW_SETUP    = 12'h014;
  localparam logic [11:0] OFS_IRQ_STATUS  = 12'h020;
  localparam logic [11:0] OFS_IRQ_MASK    = 12'h024;
  localparam logic [11:0] OFS_HW_STATE    = 12'h028;
  localparam int          TXC_FLUSH_BIT   = 0;
  localparam int          TXC_STOP_BIT    = 1;
  localparam int          TXC_ON_BIT      = 2;
  localparam int          HW_NOSTALL_BIT  = 8;
  localparam int          HW_PAD_LSB      = 9;
  localparam int          HW_LEDFAST_BIT  = 11;
  localparam int          HW_EMPTYNAK_BIT = 12;
  localparam int          HW_GUARD_BIT    = 15;
  localparam int          HW_EMUSEL_BIT   = 16;
  localparam int          IRQ_HALT_BIT    = 17;
  localparam logic [31:0] HW_WR_MASK      = 32'h0001_9F00;
  localparam logic [31:0] TXC_RESET       = 32'h0000_0000;
  localparam logic [31:0] HW_RESET        = 32'h0000_0000;
  localparam int          LED_SLOW_MS     = 80;
  localparam int          LED_FAST_US     = 15;
  localparam int          LED_SLOW_CYC    = LED_SLOW_MS * 1000 * CLK_MHZ;
  localparam int          LED_FAST_CYC    = LED_FAST_US * CLK_MHZ;
endpackage

// ==== design/txhw_link_if.sv ====
// Interface carrying register values from the register file to the engine.
`timescale 1ns/100ps
interface txhw_link_if;
  logic       tx_on;
  logic       stop_req;
  logic       led_fast;
  logic [1:0] pad;
  logic       halted_pulse;
  logic       led_level;
  modport regs (output tx_on, output stop_req, output led_fast,
                output pad, input halted_pulse, input led_level);
  modport eng  (input tx_on, input stop_req, input led_fast,
                input pad, output halted_pulse, output led_level);
endinterface

// ==== design/txhw_engine.sv ====
// Transmit halt tracker and activity light timer.
`timescale 1ns/100ps
module txhw_engine #(
  parameter int SLOW_CYC = txhw_pkg::LED_SLOW_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic frame_busy_i,
  input  wire logic activity_i,
  txhw_link_if.eng  lnk
);
  import txhw_pkg::*;
  logic [31:0] led_cnt_r;
  logic        led_r;
  logic        led_busy_r;
  logic        halt_r;
  wire  [31:0] led_limit = lnk.led_fast ? 32'(LED_FAST_CYC)
                                        : 32'(SLOW_CYC);
  wire         halt_now = lnk.stop_req && !frame_busy_i;
  // The halt event fires once, when a stop waits and the frame has ended.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      halt_r <= 1'b0;
    end else if (ce_i) begin
      halt_r <= halt_now && !halt_r;
    end
  end
  assign lnk.halted_pulse = halt_r;
  // Activity light holds on, then off, for the selected period each.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      led_cnt_r  <= 32'h0000_0000;
      led_r      <= 1'b0;
      led_busy_r <= 1'b0;
    end else if (ce_i) begin
      if (led_busy_r) begin
        if (led_cnt_r >= led_limit - 32'h0000_0001) begin
          led_cnt_r <= 32'h0000_0000;
          led_busy_r <= led_r;
          led_r <= 1'b0;
        end else begin
          led_cnt_r <= led_cnt_r + 32'h0000_0001;
        end
      end else if (activity_i) begin
        led_busy_r <= 1'b1;
        led_r <= 1'b1;
      end
    end
  end
  assign lnk.led_level = led_r;
endmodule

// ==== tb/txhw_regs_asserts.sv ====
// Concurrent checks on the register block ports.
`timescale 1ns/100ps
module txhw_regs_asserts
  import txhw_pkg::*;
(
  input wire logic        CLOCK_I,
  input wire logic        RST_N_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0]  PSTRB_I,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        TX_ENABLE_O,
  input wire logic        TX_FLUSH_O,
  input wire logic        EMPTY_NAK_O,
  input wire logic        EMPTY_ZLP_O,
  input wire logic [1:0]  RX_PAD_BYTES_O,
  input wire logic        IRQ_O
);
  wire logic hit = PADDR_I inside {OFS_TX_CTL, OFS_HW_SETUP,
                   OFS_IRQ_STATUS, OFS_IRQ_MASK, OFS_HW_STATE};
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  sequence flush_wr_s;
    PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == OFS_TX_CTL;
  endsequence
  sequence flush_seen_s;
    PWDATA_I[TXC_FLUSH_BIT] && PSTRB_I[0] && PREADY_O;
  endsequence
  pready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held too long");
  access_ready_a: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
    else $error("no ready in access cycle");
  unmapped_err_a: assert property (PREADY_O && !hit |-> PSLVERR_O)
    else $error("unmapped access without error");
  flush_pulse_a: assert property (TX_FLUSH_O |=> !TX_FLUSH_O)
    else $error("flush longer than one cycle");
  flush_after_a: assert property (flush_wr_s and flush_seen_s
    |-> ##[1:3] TX_FLUSH_O) else $error("flush missing");
  reply_excl_a: assert property (!(EMPTY_NAK_O && EMPTY_ZLP_O))
    else $error("both empty replies");
  irq_sticky_a: assert property (IRQ_O && !PSEL_I && !$past(PSEL_I)
    && !$past(PSEL_I, 2) |=> IRQ_O) else $error("irq dropped");
  pad_change_a: assert property (!$stable(RX_PAD_BYTES_O)
    |-> $past(PENABLE_I) || $past(PENABLE_I, 2) || $past(PENABLE_I, 3))
    else $error("pad changed without write");
  enable_rise_a: assert property ($rose(TX_ENABLE_O)
    |-> $past(PENABLE_I) || $past(PENABLE_I, 2) || $past(PENABLE_I, 3))
    else $error("enable rose without write");
endmodule
bind txhw_regs txhw_regs_asserts u_asserts (.CLOCK_I, .RST_N_I, .PSEL_I,
  .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PSTRB_I, .PREADY_O,
  .PSLVERR_O, .TX_ENABLE_O, .TX_FLUSH_O, .EMPTY_NAK_O, .EMPTY_ZLP_O,
  .RX_PAD_BYTES_O, .IRQ_O);

// ==== tb/apb_host_model.sv ====
// Bus master that plays the host driver on the register bus.
`timescale 1ns/100ps
module apb_host_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [11:0]      paddr_o,
  output logic [31:0]      pwdata_o,
  output logic [3:0]       pstrb_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0000_0000;
    pstrb_o = 4'hF;
  end
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule

// ==== tb/tx_control_hw_config_regs_test.sv ====
// Self-checking bench for the transmit control and setup registers.
`timescale 1ns/100ps
module tx_control_hw_config_regs_test;
  import txhw_pkg::*;
  logic        clk, rst_n, por_n, busy, prom, rxe, slost, act, err;
  logic        psel, pen, pwr, pready, slverr, ten, fl, udr, nak, zlp;
  logic        stall, led, irq, ce;
  logic [1:0]  pad;
  logic [3:0]  pstrb;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int          error_cnt, total_checks, fl_cnt, led_cnt;
  apb_host_model u_apb_host_model (.clk_i(clk), .prdata_i(prdata),
    .pready_i(pready), .pslverr_i(slverr), .psel_o(psel), .penable_o(pen),
    .pwrite_o(pwr), .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb));
  txhw_regs #(.SLOW_CYC(50)) u_txhw_regs (.CLOCK_I(clk), .RST_N_I(rst_n),
    .POR_N_I(por_n), .CE_I(ce), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
    .FRAME_BUSY_I(busy), .PROM_PRESENT_I(prom), .RX_EMPTY_I(rxe),
    .SYNC_LOST_I(slost), .ACTIVITY_I(act), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(slverr), .TX_ENABLE_O(ten),
    .TX_FLUSH_O(fl), .USE_DESC_RAM_O(udr), .EMPTY_NAK_O(nak),
    .EMPTY_ZLP_O(zlp), .OUTPIPE_STALL_O(stall), .RX_PAD_BYTES_O(pad),
    .ACT_LED_O(led), .IRQ_O(irq));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk) begin
    fl_cnt += int'(fl === 1'b1);
    led_cnt += int'(led === 1'b1);
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    u_apb_host_model.xfer(1'b1, a, d, q, err);
  endtask
  task rd(input logic [11:0] a);
    u_apb_host_model.xfer(1'b0, a, 32'h0000_0000, q, err);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task pulse_reset;
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(3);
  endtask
  task t_setup;
    rd(OFS_TX_CTL);
    chk(q, TXC_RESET);
    rd(OFS_HW_SETUP);
    chk(q, HW_RESET);
    wr(OFS_HW_SETUP, 32'hFFFF_FFFF);
    rd(OFS_HW_SETUP);
    chk(q, HW_WR_MASK);
    cyc(5);
    chk(32'({nak, zlp, stall, udr, pad}), 32'h27);
    prom <= 1'b1;
    cyc(5);
    chk(32'(udr), 32'h0);
    wr(OFS_HW_SETUP, 32'h0000_0000);
    cyc(5);
    chk(32'({nak, zlp, stall, pad}), 32'h0C);
    rd(12'h0FC);
    chk(32'(err), 32'h1);
  endtask
  task t_guard;
    wr(OFS_HW_SETUP, 32'h0001_9000);
    pulse_reset;
    rd(OFS_HW_SETUP);
    chk(q, 32'h0001_8000);
    wr(OFS_HW_SETUP, 32'h0000_1000);
    pulse_reset;
    rd(OFS_HW_SETUP);
    chk(q, 32'h0000_0000);
  endtask
  task t_stop;
    wr(OFS_IRQ_MASK, 32'h0002_0000);
    busy <= 1'b1;
    wr(OFS_TX_CTL, 32'h0000_0004);
    cyc(2);
    chk(32'(ten), 32'h1);
    wr(OFS_TX_CTL, 32'h0000_0006);
    wr(OFS_TX_CTL, 32'h0000_0004);
    rd(OFS_TX_CTL);
    chk(q, 32'h0000_0006);
    busy <= 1'b0;
    cyc(8);
    rd(OFS_TX_CTL);
    chk(q, 32'h0000_0000);
    rd(OFS_HW_STATE);
    chk(q & 32'h0000_0002, 32'h0000_0000);
    chk(32'({ten, irq}), 32'h1);
    rd(OFS_IRQ_STATUS);
    chk(q, 32'h0002_0000);
    wr(OFS_IRQ_STATUS, 32'h0002_0000);
    cyc(3);
    chk(32'(irq), 32'h0);
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    wr(OFS_TX_CTL, 32'h0000_0006);
    cyc(8);
    chk(32'(irq), 32'h0);
    rd(OFS_IRQ_STATUS);
    chk(q, 32'h0002_0000);
  endtask
  task t_flush;
    fl_cnt = 0;
    wr(OFS_TX_CTL, 32'h0000_0001);
    cyc(4);
    chk(32'(fl_cnt), 32'h1);
    rd(OFS_TX_CTL);
    chk(q, 32'h0000_0000);
  endtask
  task t_led(input logic fast, input int lo, input int hi);
    wr(OFS_HW_SETUP, {20'h0, fast, 11'h000});
    led_cnt = 0;
    act <= 1'b1;
    cyc(1);
    act <= 1'b0;
    cyc(2 * hi + 20);
    chk(32'(led_cnt >= lo && led_cnt <= hi), 32'h1);
  endtask
  task t_freeze;
    ce <= 1'b0;
    slost <= 1'b0;
    cyc(6);
    chk(32'(stall), 32'h1);
    ce <= 1'b1;
    cyc(6);
    chk(32'(stall), 32'h0);
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    {rst_n, por_n, busy, prom, act} = 5'h00;
    {rxe, slost} = 2'h3;
    ce = 1'b1;
    error_cnt = 0;
    total_checks = 0;
    cyc(8);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    cyc(3);
    t_setup;
    t_guard;
    t_stop;
    t_flush;
    t_led(1'b0, 48, 52);
    t_led(1'b1, 3740, 3760);
    t_freeze;
    tally_and_finish;
  end
  initial begin
    cyc(30000);
    error_cnt++;
    tally_and_finish;
  end
endmodule
